// [src/irq_ready_pkg.sv]
// Purpose: Shared constants and types for the four-channel interrupt and ready output logic
// Assumes: 8-bit register port, one clock
// Notes: Register offsets are word indices on the plain register port
package irq_ready_pkg;
  localparam int NumChan = 4;
  localparam int AddrWidth = 4;
  localparam int DataWidth = 8;
  localparam logic [3:0] ModemCtrlBaseAddr = 4'h0;
  localparam logic [3:0] IntStatusAddr = 4'h4;
  localparam logic [3:0] IntClearAddr = 4'h5;
  localparam logic [3:0] IntEnableAddr = 4'h6;
  localparam logic [3:0] LiveStatusAddr = 4'h7;
  localparam int IrqOutputEnableBit = 3;
  localparam logic [7:0] ModemCtrlReset = 8'h00;
  localparam logic [7:0] IntEnableReset = 8'h00;
  localparam logic [7:0] UnmappedReadValue = 8'h00;
  localparam int EvtTxLsb = 0;
  localparam int EvtRxLsb = 4;
  localparam int LiveTxBit = 0;
  localparam int LiveRxBit = 1;
  localparam int LiveIrqSelBit = 2;
  localparam int LiveBusModeBit = 3;
  localparam int LiveReqLsb = 4;

  typedef struct packed {
    logic [3:0] txReadyN;
    logic [3:0] rxReadyN;
  } chan_ready_t;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } irq_pins_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// [src/quad_uart_irq_ready_outputs.sv]
// Purpose: Interrupt pin gating and transmit/receive ready outputs of a four-channel UART
// Assumes: Channel request and ready levels come from UART logic on clk; mode pins are static straps
// Notes: Pin outputs are combinational from synchronised pins and same-clock inputs
//
// Summary of operation
// [R1] Strobe-style bus: separate interrupt outputs for channels A, B, C and D.
// [R2] Strobe mode, select low: channel interrupt driven when its enable bit is 1.
// [R3] Strobe mode, select low: interrupt floats when enable bit is 0; bit resets 0.
// [R4] Read/write-line bus: channel B, C, D interrupt outputs held at logic zero.
// [R5] Strobe mode, select high: all interrupt outputs driven regardless of enable bit.
// [R6] Strobe mode, select low: enable bit 3 of modem control alone gates the pins.
// [R7] Interrupt-select input is active high and reads low when unconnected.
// [R8] System holds interrupt-select low in read/write-line bus mode.
// [R9] Per-channel active-low transmit ready outputs mirror each channel's transmit status.
// [R10] Per-channel active-low receive ready outputs mirror each channel's receive status.
// [R11] Combined transmit ready is the AND of the four per-channel signals.
// [R12] Combined receive ready is the AND of the four per-channel signals.
// [R13] Read/write-line bus: channel A pin is device-wide active-low open-drain interrupt.
// [R14] Bus-style pin high selects strobe bus, low selects read/write-line bus.
// [R15] Ready and request levels come from channels; this block only gates and combines.
// [R16] Enabled strobe-mode interrupt follows the pending request with no added latency.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module quad_uart_irq_ready_outputs #(
  parameter int NumChan = irq_ready_pkg::NumChan
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic busModeSelPin,
  input wire logic irqContinuousSelectPin,
  input wire logic [3:0] chanIrqReq,
  input wire irq_ready_pkg::chan_ready_t chanReady,
  input wire irq_ready_pkg::reg_req_t regReq,
  output logic [7:0] regRdata,
  output irq_ready_pkg::irq_pins_t chanIrqPins,
  output logic [3:0] chanTxReadyN,
  output logic [3:0] chanRxReadyN,
  output logic combinedTxReadyN,
  output logic combinedRxReadyN,
  output logic irqOut
);

  // Straps come from pins, so they cross two flops before use
  logic busModeMeta_reg;
  logic busModeSync_reg;
  logic irqSelMeta_reg;
  logic irqSelSync_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busModeMeta_reg <= 1'b0;
      busModeSync_reg <= 1'b0;
      irqSelMeta_reg <= 1'b0;
      irqSelSync_reg <= 1'b0;
    end else begin
      busModeMeta_reg <= busModeSelPin;
      busModeSync_reg <= busModeMeta_reg;
      irqSelMeta_reg <= irqContinuousSelectPin;
      irqSelSync_reg <= irqSelMeta_reg;
    end
  end

  wire strobeBus = busModeSync_reg; // R14
  // Active high; an open pin is pulled down outside, so it reads as low here
  wire irqSel = irqSelSync_reg; // R7
  // Continuous select is only honoured on the strobe bus, as the system keeps it low otherwise
  wire irqSelEffective = irqSel & strobeBus; // R8

  // Register port decode
  wire [3:0] addr = regReq.addr;
  wire isModemCtrl = (addr[3:2] == irq_ready_pkg::ModemCtrlBaseAddr[3:2]);
  wire [1:0] chanSel = addr[1:0];
  wire wrModemCtrl = regReq.wr & isModemCtrl;
  wire wrIntClear = regReq.wr & (addr == irq_ready_pkg::IntClearAddr);
  wire wrIntEnable = regReq.wr & (addr == irq_ready_pkg::IntEnableAddr);

  // Modem control registers, one per channel
  logic [7:0] modemCtrl_reg [NumChan];
  logic [NumChan-1:0] irqOutputEnableBit;

  genvar ch;
  generate
    for (ch = 0; ch < NumChan; ch++) begin : gMcr
      wire wrThis = wrModemCtrl & (chanSel == 2'(ch));
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          modemCtrl_reg[ch] <= irq_ready_pkg::ModemCtrlReset; // R3
        end else if (wrThis) begin
          modemCtrl_reg[ch] <= regReq.wdata;
        end
      end
      assign irqOutputEnableBit[ch] = modemCtrl_reg[ch][irq_ready_pkg::IrqOutputEnableBit]; // R6
    end
  endgenerate

  // Per-channel ready outputs pass straight through from the channels; combined ones AND them
  assign chanTxReadyN = chanReady.txReadyN; // R9 R15
  assign chanRxReadyN = chanReady.rxReadyN; // R10 R15
  assign combinedTxReadyN = &chanReady.txReadyN; // R11
  assign combinedRxReadyN = &chanReady.rxReadyN; // R12

  // Interrupt pin gating
  wire anyReq = |chanIrqReq;
  wire [3:0] strobeOe = {4{irqSelEffective}} | irqOutputEnableBit; // R2 R3 R5 R6
  // Combinational on purpose: a registered stage would add a cycle to every interrupt
  wire [3:0] strobeLevel = chanIrqReq; // R16
  // Read/write-line bus: A is open drain, low while any channel is pending
  wire [3:0] rwLevel = 4'h0; // R4 R13
  wire [3:0] rwOe = {3'b111, anyReq}; // R4 R13

  assign chanIrqPins.level = strobeBus ? strobeLevel : rwLevel; // R1 R14
  assign chanIrqPins.oe = strobeBus ? strobeOe : rwOe; // R1 R4

  // Sticky events: a ready output becoming active
  logic [3:0] txPrevN_reg;
  logic [3:0] rxPrevN_reg;
  logic [7:0] intStatus_reg;
  logic [7:0] intStatus_next;
  logic [7:0] intEnable_reg;

  wire [3:0] txAssert = txPrevN_reg & ~chanReady.txReadyN;
  wire [3:0] rxAssert = rxPrevN_reg & ~chanReady.rxReadyN;
  wire [7:0] events = {rxAssert, txAssert};
  wire [7:0] clearMask = wrIntClear ? regReq.wdata : 8'h00;

  // Set beats clear so an event in the clearing cycle survives
  assign intStatus_next = (intStatus_reg & ~clearMask) | events;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txPrevN_reg <= 4'hf;
      rxPrevN_reg <= 4'hf;
      intStatus_reg <= 8'h00;
      intEnable_reg <= irq_ready_pkg::IntEnableReset;
    end else begin
      txPrevN_reg <= chanReady.txReadyN;
      rxPrevN_reg <= chanReady.rxReadyN;
      intStatus_reg <= intStatus_next;
      if (wrIntEnable) begin
        intEnable_reg <= regReq.wdata;
      end
    end
  end

  assign irqOut = |(intStatus_reg & intEnable_reg);

  // Read path
  wire [7:0] liveStatus = {chanIrqReq, busModeSync_reg, irqSelSync_reg, combinedRxReadyN, combinedTxReadyN};
  wire [7:0] modemCtrlRd = modemCtrl_reg[chanSel];
  wire [7:0] rdMux = isModemCtrl ? modemCtrlRd :
                     (addr == irq_ready_pkg::IntStatusAddr) ? intStatus_reg :
                     (addr == irq_ready_pkg::IntEnableAddr) ? intEnable_reg :
                     (addr == irq_ready_pkg::LiveStatusAddr) ? liveStatus :
                     irq_ready_pkg::UnmappedReadValue;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regReq.rd) begin
      regRdata <= rdMux;
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// [sim/irq_ready_properties.sv]
// Purpose: Port assertions for irq and ready outputs
// Assumes: Straps only change between quiet phases
// Notes: Three-edge strap windows cover the 2-flop sync
`timescale 1ns/1ps
`default_nettype none
module irq_ready_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic busModeSelPin,
  input wire logic irqContinuousSelectPin,
  input wire logic [3:0] chanIrqReq,
  input wire irq_ready_pkg::chan_ready_t chanReady,
  input wire irq_ready_pkg::reg_req_t regReq,
  input wire logic [7:0] regRdata,
  input wire irq_ready_pkg::irq_pins_t chanIrqPins,
  input wire logic [3:0] chanTxReadyN,
  input wire logic [3:0] chanRxReadyN,
  input wire logic combinedTxReadyN,
  input wire logic combinedRxReadyN,
  input wire logic irqOut
);
  wire logic [3:0] oe = chanIrqPins.oe;
  wire logic [3:0] lvl = chanIrqPins.level;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_ready_copy: assert property ({chanTxReadyN, chanRxReadyN} == chanReady)
    else $error("ready copy wrong");
  chk_tx_and: assert property (combinedTxReadyN == &chanReady.txReadyN)
    else $error("combined tx wrong");
  chk_rx_and: assert property (combinedRxReadyN == &chanReady.rxReadyN)
    else $error("combined rx wrong");
  chk_rw_quiet: assert property (!busModeSelPin [*3] |-> lvl == 4'h0 && oe[3:1] == 3'h7)
    else $error("unused pins not low");
  chk_rw_shared: assert property (!busModeSelPin [*3] |-> oe[0] == |chanIrqReq)
    else $error("shared pin wrong");
  chk_strobe_level: assert property (busModeSelPin [*3] |-> lvl == chanIrqReq)
    else $error("irq level wrong");
  chk_sel_override: assert property ((busModeSelPin && irqContinuousSelectPin) [*3] |-> oe == 4'hf)
    else $error("override not driving");
  chk_enable_gate: assert property ((busModeSelPin && !irqContinuousSelectPin) [*3] ##0 regReq.wr
    && regReq.addr[3:2] == 2'h0 ##1 !irqContinuousSelectPin |-> oe[$past(regReq.addr[1:0])] == $past(regReq.wdata[3]))
    else $error("enable bit not gating");
endmodule
bind quad_uart_irq_ready_outputs irq_ready_properties irq_ready_properties_i (.clk, .rst_n, .busModeSelPin,
  .irqContinuousSelectPin, .chanIrqReq, .chanReady, .regReq, .regRdata, .chanIrqPins, .chanTxReadyN,
  .chanRxReadyN, .combinedTxReadyN, .combinedRxReadyN, .irqOut);
`default_nettype wire

// [sim/host_irq_model.sv]
// Purpose: Host side straps and interrupt wires
// Assumes: Undriven wires without a pull flip each cycle
// Notes: Select is forced low outside strobe mode
`timescale 1ns/1ps
`default_nettype none
module host_irq_model (
  input wire logic clk,
  input wire logic wantBus,
  input wire logic wantSel,
  input wire logic selFloat,
  input wire irq_ready_pkg::irq_pins_t pins,
  output logic busPin,
  output logic selPin,
  output logic [3:0] irqWire
);
  logic [3:0] lastWire = 4'h0;
  assign busPin = wantBus;
  assign selPin = !selFloat && wantSel && wantBus;
  always_comb begin
    for (int i = 0; i < 4; i++) irqWire[i] = pins.oe[i] ? pins.level[i] : ~lastWire[i];
    if (!busPin && !pins.oe[0]) irqWire[0] = 1'b1;
  end
  always_ff @(posedge clk) lastWire <= irqWire;
endmodule
`default_nettype wire

// [sim/test_quad_uart_irq_ready_outputs.sv]
// Purpose: Random and corner tests of irq and ready outputs
// Assumes: Straps settle for three edges before checks
// Notes: Select float phase shows the pull-down reading low
`timescale 1ns/1ps
`default_nettype none
module test_quad_uart_irq_ready_outputs;
  logic clk = 1'b0, rst_n = 1'b0, wantBus = 1'b0, wantSel = 1'b0, selFloat = 1'b0;
  logic busPin, selPin, irqOut, combTx, combRx;
  logic [3:0] req = 4'h0, txN, rxN, irqWire, en;
  logic [7:0] rdata, got;
  logic [2:0] phases [4] = '{3'h0, 3'h4, 3'h6, 3'h7};
  irq_ready_pkg::chan_ready_t rdy = 8'hff;
  irq_ready_pkg::reg_req_t rq = '0;
  irq_ready_pkg::irq_pins_t pins;
  int seed = 70985, miscompares = 0, checks = 0, cycles = 0;
  always #12.5 clk = ~clk;
  quad_uart_irq_ready_outputs quad_uart_irq_ready_outputs_i (.clk(clk), .rst_n(rst_n), .busModeSelPin(busPin),
    .irqContinuousSelectPin(selPin), .chanIrqReq(req), .chanReady(rdy), .regReq(rq), .regRdata(rdata),
    .chanIrqPins(pins), .chanTxReadyN(txN), .chanRxReadyN(rxN), .combinedTxReadyN(combTx),
    .combinedRxReadyN(combRx), .irqOut(irqOut));
  host_irq_model host_irq_model_i (.clk(clk), .wantBus(wantBus), .wantSel(wantSel), .selFloat(selFloat),
    .pins(pins), .busPin(busPin), .selPin(selPin), .irqWire(irqWire));
  function automatic irq_ready_pkg::irq_pins_t expPins(input logic bus, sel, input logic [3:0] e, r);
    expPins.level = bus ? r : 4'h0;
    expPins.oe = bus ? (sel ? 4'hf : e) : {3'h7, |r};
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) rq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) rq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk) rq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) rq.rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic checkPins(input logic sel);
    @(posedge clk) req <= 4'($random(seed));
    rdy <= 8'($random(seed));
    #1 chk("pins", pins, expPins(wantBus, sel, en, req));
    chk("ready", {txN, rxN}, rdy);
    chk("all ready", {6'h0, combTx, combRx}, {6'h0, &rdy.txReadyN, &rdy.rxReadyN});
    if (!wantBus) chk("shared wire", {7'h0, irqWire[0]}, {7'h0, ~|req});
  endtask
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(a[3:0]);
      chk("enable reset", got, 8'h00);
    end
    for (int p = 0; p < 4; p++) begin
      @(posedge clk) {wantBus, wantSel, selFloat} <= phases[p];
      repeat (3) @(posedge clk);
      repeat (6) begin
        en = 4'($random(seed));
        for (int c = 0; c < 4; c++) wr(c[3:0], {4'h0, en[c], 3'h0});
        repeat (4) checkPins(wantSel && !selFloat);
      end
      $display("phase %0d done", p);
    end
    @(posedge clk) rdy <= 8'hff;
    wr(4'h6, 8'h04);
    wr(4'h5, 8'hff);
    @(posedge clk) rdy.txReadyN[2] <= 1'b0;
    rd(4'h4);
    chk("status", got, 8'h04);
    chk("irq", {7'h0, irqOut}, 8'h01);
    wr(4'h6, 8'h00);
    #1 chk("masked", {7'h0, irqOut}, 8'h00);
    wr(4'h6, 8'h04);
    wr(4'h5, 8'h04);
    #1 chk("cleared", {7'h0, irqOut}, 8'h00);
    @(posedge clk) rdy.rxReadyN[1] <= 1'b0;
    rd(4'h4);
    chk("rx status", got, 8'h20);
    rd(4'h7);
    chk("live", got, {req, 1'b1, 1'b0, 1'b0, 1'b0});
    rd(4'h9);
    chk("unmapped", got, 8'h00);
    @(posedge clk) #1 chk("idle rdata", rdata, 8'h00);
    $display("interrupt test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
